// >>> common/hwmon_pkg.sv
`default_nettype none
package hwmon_pkg;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic [1:0] ALIGN_OK      = 2'h0;
  localparam logic [21:0] HIGH_ZERO    = 22'h0;

  localparam logic [7:0] BANK_CTL_IDX  = 8'h4E;
  localparam logic [7:0] MAKER_ID_IDX  = 8'h4F;
  localparam logic [7:0] BANKED_LO     = 8'h50;
  localparam logic [7:0] BANKED_HI     = 8'h5F;
  localparam logic [7:0] BEEP_ONE_IDX  = 8'h56;
  localparam logic [7:0] BEEP_TWO_IDX  = 8'h57;
  localparam logic [7:0] PART_ID_IDX   = 8'h58;
  localparam logic [7:0] DIODE_IDX     = 8'h59;
  localparam logic [7:0] BATT_CTL_IDX  = 8'h5D;
  localparam logic [7:0] CRIT_IDX      = 8'h5E;
  localparam logic [7:0] PWM_FREQ_IDX  = 8'h60;
  localparam logic [7:0] OUT_VALUE_IDX = 8'h61;
  localparam logic [7:0] FAN_CFG_IDX   = 8'h62;
  localparam logic [7:0] BATT_READ_IDX = 8'h70;
  localparam logic [2:0] BANK_ZERO     = 3'h0;

  typedef enum logic [1:0] {
    MODE_MANUAL      = 2'b00,
    MODE_TEMP_TRACK  = 2'b01,
    MODE_SPEED_TRACK = 2'b10,
    MODE_STEPWISE    = 2'b11
  } ctrl_mode_t;

  typedef struct packed {
    logic       hbs;
    logic       rsv6;
    logic       beep_aux2;
    logic       beep_cpu2;
    logic       rsv3;
    logic [2:0] bank;
  } bank_ctl_t;
  typedef struct packed {
    logic cpu_fan;
    logic sys_fan;
    logic cpu_temp;
    logic sys_temp;
    logic rail_3v3;
    logic analog;
    logic volt0;
    logic core;
  } beep_one_t;
  typedef struct packed {
    logic gate;
    logic volt4;
    logic aux_temp;
    logic intrusion;
    logic aux_fan;
    logic volt3;
    logic volt2;
    logic volt1;
  } beep_two_t;
  typedef struct packed {
    logic       aux2_div_hi;
    logic       diode_aux;
    logic       diode_cpu;
    logic       diode_sys;
    logic [1:0] aux2_div_lo;
    logic [1:0] cpu2_div_lo;
  } diode_t;
  typedef struct packed {
    logic aux_div_hi;
    logic cpu_div_hi;
    logic sys_div_hi;
    logic rsv4;
    logic type_aux;
    logic type_cpu;
    logic type_sys;
    logic batt_en;
  } batt_ctl_t;
  typedef struct packed {
    logic crit_cpu2;
    logic crit_aux;
    logic crit_cpu1;
    logic crit_sys;
    logic cur_aux;
    logic cur_cpu;
    logic cur_sys;
    logic rsv0;
  } crit_t;
  typedef struct packed {
    logic       slow_clk;
    logic [6:0] prescale;
  } freq_t;
  typedef struct packed {
    logic       rsv7;
    logic       dc_mode;
    ctrl_mode_t mode;
    logic [3:0] tolerance;
  } fan_cfg_t;
  typedef struct packed {
    diode_t    diode;
    batt_ctl_t batt;
    crit_t     crit;
    fan_cfg_t  fan;
  } cfg_t;

  localparam bank_ctl_t BANK_CTL_RST = 8'h80;
  localparam logic [7:0] BANK_CTL_MASK = 8'hB7;
  localparam beep_one_t BEEP_ONE_RST = 8'h00;
  localparam beep_two_t BEEP_TWO_RST = 8'h80;
  localparam diode_t    DIODE_RST    = 8'h70;
  localparam batt_ctl_t BATT_CTL_RST = 8'h04;
  localparam logic [7:0] BATT_MASK   = 8'hEF;
  localparam crit_t     CRIT_RST     = 8'h04;
  localparam logic [7:0] CRIT_MASK   = 8'hFE;
  localparam freq_t     FREQ_RST     = 8'h04;
  localparam fan_cfg_t  FAN_CFG_RST  = 8'h40;
  localparam logic [7:0] FAN_CFG_MASK = 8'h7F;
  localparam logic [7:0] STRAP_HI_VALUE = 8'hFF;
  localparam logic [7:0] STRAP_LO_VALUE = 8'h80;
  localparam logic [7:0] DUTY_FULL   = 8'hFF;
  localparam logic [1:0] STRAP_WAIT_LAST = 2'h3;

  localparam int SYS_CLK_KHZ  = 125000;
  localparam int PWM_FAST_KHZ = 24000;
  localparam int PWM_SLOW_KHZ = 180;

  typedef struct packed {
    bank_ctl_t   bank;
    beep_one_t   beep_one;
    beep_two_t   beep_two;
    diode_t      diode;
    batt_ctl_t   batt;
    crit_t       crit;
    freq_t       freq;
    logic [7:0]  out_value;
    fan_cfg_t    fan;
    logic [7:0]  batt_read;
    logic        wr_pend;
    logic [7:0]  wr_idx;
    logic [31:0] hrdata;
    beep_one_t   al1_m;
    beep_one_t   al1_s;
    beep_two_t   al2_m;
    beep_two_t   al2_s;
    logic        strap_m;
    logic        strap_s;
    logic [1:0]  strap_wait;
    logic        strap_done;
    logic [7:0]  adc_m;
    logic [7:0]  adc_s;
    logic        beep;
    logic [16:0] acc_fast;
    logic [16:0] acc_slow;
    logic [6:0]  pre_cnt;
    logic [7:0]  pwm_cnt;
    logic        pwm_out;
    logic [5:0]  dc_level;
    logic        batt_en_d;
    logic [16:0] mon_cnt;
    logic        batt_sample;
  } st_t;
endpackage
`default_nettype wire

// >>> rtl/hwmon_regs.sv
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module hwmon_regs #(
  parameter logic [15:0] MAKER_ID = 16'h1234, // arbitrary value
  parameter logic [7:0]  PART_ID  = 8'h2A,    // arbitrary value
  parameter int MON_CYCLE_CYCLES  = 125000
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic                      hresp,
  output logic [31:0]               hrdata,
  // monitor side
  input  wire hwmon_pkg::beep_one_t alarm_one,
  input  wire hwmon_pkg::beep_two_t alarm_two,
  input  wire logic [7:0]           battery_adc,
  input  wire logic                 fan_default_strap,
  output logic                      beep,
  output logic                      battery_sample,
  // second cpu fan drive, second aux fan tach divisor and config
  output logic                      cpu_fan_drive_second_pwm,
  output logic [5:0]                cpu_fan_drive_second_dc,
  output logic [7:0]                aux_fan_tach_second_div,
  output hwmon_pkg::cfg_t           cfg
);
  import hwmon_pkg::*;

  localparam logic [16:0] FAST_STEP = 17'(PWM_FAST_KHZ);
  localparam logic [16:0] SLOW_STEP = 17'(PWM_SLOW_KHZ);
  localparam logic [16:0] ACC_MOD   = 17'(SYS_CLK_KHZ);
  localparam logic [16:0] MON_LAST  = 17'(MON_CYCLE_CYCLES - 1);

  st_t  s_r;
  st_t  s_n;
  logic take;
  logic [7:0] a_idx;
  logic fast_tick;
  logic slow_tick;
  logic src_tick;
  logic [16:0] fast_acc;
  logic [16:0] slow_acc;
  logic [6:0] pre_last;

  // fractional clock source: tick on wrap
  function automatic logic [17:0] acc_step(input logic [16:0] acc,
                                           input logic [16:0] step);
    logic [17:0] sum;
    sum = {1'b0, acc} + {1'b0, step};
    if (sum >= {1'b0, ACC_MOD})
      acc_step = {1'b1, 17'(sum - {1'b0, ACC_MOD})};
    else
      acc_step = {1'b0, sum[16:0]};
  endfunction

  // tach divisor code to division factor
  function automatic logic [7:0] fan_divisor(input logic [2:0] code);
    fan_divisor = 8'h01 << code;
  endfunction

  function automatic logic banked_ok(input logic [7:0] idx,
                                     input logic [2:0] bank);
    banked_ok = (idx < BANKED_LO) || (idx > BANKED_HI)
             || (bank == BANK_ZERO);
  endfunction

  function automatic logic [7:0] read_reg(input logic [7:0] idx,
                                          input st_t st);
    read_reg = 8'h00;
    if (banked_ok(idx, st.bank.bank))
    begin
      unique case (idx)
        BANK_CTL_IDX:  read_reg = st.bank;
        MAKER_ID_IDX:  read_reg = st.bank.hbs ? MAKER_ID[15:8]
                                              : MAKER_ID[7:0];
        BEEP_ONE_IDX:  read_reg = st.beep_one;
        BEEP_TWO_IDX:  read_reg = st.beep_two;
        PART_ID_IDX:   read_reg = PART_ID;
        DIODE_IDX:     read_reg = st.diode;
        BATT_CTL_IDX:  read_reg = st.batt;
        CRIT_IDX:      read_reg = st.crit;
        PWM_FREQ_IDX:  read_reg = st.freq;
        OUT_VALUE_IDX: read_reg = st.out_value;
        FAN_CFG_IDX:   read_reg = st.fan;
        BATT_READ_IDX: read_reg = st.batt_read;
        default:       read_reg = 8'h00;
      endcase
    end
  endfunction

  assign take = hsel && hready && (htrans == HTRANS_NONSEQ)
             && (hsize == HSIZE_WORD) && (haddr[1:0] == ALIGN_OK)
             && (haddr[31:10] == HIGH_ZERO);
  assign a_idx = haddr[9:2];
  assign {fast_tick, fast_acc} = acc_step(s_r.acc_fast, FAST_STEP);
  assign {slow_tick, slow_acc} = acc_step(s_r.acc_slow, SLOW_STEP);
  assign src_tick = s_r.freq.slow_clk ? slow_tick : fast_tick;
  assign pre_last = (s_r.freq.prescale == 7'h00) ? 7'h00
                  : 7'(s_r.freq.prescale - 7'h01);

  always_comb
  begin
    s_n = s_r;
    // input synchronisers
    s_n.al1_m   = alarm_one;
    s_n.al1_s   = s_r.al1_m;
    s_n.al2_m   = alarm_two;
    s_n.al2_s   = s_r.al2_m;
    s_n.strap_m = fan_default_strap;
    s_n.strap_s = s_r.strap_m;
    s_n.adc_m   = battery_adc;
    s_n.adc_s   = s_r.adc_m;

    // data phase of a write
    if (s_r.wr_pend && banked_ok(s_r.wr_idx, s_r.bank.bank))
    begin
      unique case (s_r.wr_idx)
        BANK_CTL_IDX:  s_n.bank = bank_ctl_t'(hwdata[7:0] & BANK_CTL_MASK);
        BEEP_ONE_IDX:  s_n.beep_one = beep_one_t'(hwdata[7:0]);
        BEEP_TWO_IDX:  s_n.beep_two = beep_two_t'(hwdata[7:0]);
        DIODE_IDX:     s_n.diode = diode_t'(hwdata[7:0]);
        BATT_CTL_IDX:  s_n.batt = batt_ctl_t'(hwdata[7:0] & BATT_MASK);
        CRIT_IDX:      s_n.crit = crit_t'(hwdata[7:0] & CRIT_MASK);
        PWM_FREQ_IDX:  s_n.freq = freq_t'(hwdata[7:0]);
        OUT_VALUE_IDX: s_n.out_value = hwdata[7:0];
        FAN_CFG_IDX:   s_n.fan = fan_cfg_t'(hwdata[7:0] & FAN_CFG_MASK);
        default:       s_n.wr_pend = 1'b0;
      endcase
    end

    // strap captured once, after the synchroniser has settled
    if (!s_r.strap_done)
    begin
      if (s_r.strap_wait == STRAP_WAIT_LAST)
      begin
        s_n.out_value  = s_r.strap_s ? STRAP_HI_VALUE : STRAP_LO_VALUE;
        s_n.strap_done = 1'b1;
      end
      else
        s_n.strap_wait = 2'(s_r.strap_wait + 2'h1);
    end

    // address phase
    s_n.wr_pend = take && hwrite;
    s_n.wr_idx  = a_idx;
    if (take && !hwrite)
      s_n.hrdata = {24'h0, read_reg(a_idx, s_n)};

    // beep
    s_n.beep = s_r.beep_two.gate
            && (|(s_r.al1_s & s_r.beep_one)
             || |(7'(s_r.al2_s) & 7'(s_r.beep_two)));

    // pwm generation
    s_n.acc_fast = fast_acc;
    s_n.acc_slow = slow_acc;
    if (src_tick)
    begin
      if (s_r.pre_cnt >= pre_last)
      begin
        s_n.pre_cnt = 7'h00;
        s_n.pwm_cnt = 8'(s_r.pwm_cnt + 8'h01);
      end
      else
        s_n.pre_cnt = 7'(s_r.pre_cnt + 7'h01);
    end
    // restart the prescaler when its setting changes
    if (s_n.freq != s_r.freq)
      s_n.pre_cnt = 7'h00;
    s_n.pwm_out = !s_r.fan.dc_mode
               && ((s_r.out_value == DUTY_FULL)
                || (s_r.pwm_cnt < s_r.out_value));
    s_n.dc_level = s_r.fan.dc_mode ? s_r.out_value[7:2] : 6'h00;

    // battery monitor cycle
    s_n.batt_en_d   = s_r.batt.batt_en;
    s_n.batt_sample = 1'b0;
    if (!s_r.batt.batt_en || !s_r.batt_en_d)
      s_n.mon_cnt = 17'h0;
    else if (s_r.mon_cnt == MON_LAST)
    begin
      s_n.mon_cnt     = 17'h0;
      s_n.batt_sample = 1'b1;
      s_n.batt_read   = s_r.adc_s;
    end
    else
      s_n.mon_cnt = 17'(s_r.mon_cnt + 17'h1);
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      s_r          <= '0;
      s_r.bank     <= BANK_CTL_RST;
      s_r.beep_one <= BEEP_ONE_RST;
      s_r.beep_two <= BEEP_TWO_RST;
      s_r.diode    <= DIODE_RST;
      s_r.batt     <= BATT_CTL_RST;
      s_r.crit     <= CRIT_RST;
      s_r.freq     <= FREQ_RST;
      s_r.fan      <= FAN_CFG_RST;
    end
    else
      s_r <= s_n;
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_r.hrdata;
  assign beep      = s_r.beep;
  assign battery_sample = s_r.batt_sample;
  assign cpu_fan_drive_second_pwm = s_r.pwm_out;
  assign cpu_fan_drive_second_dc  = s_r.dc_level;
  assign aux_fan_tach_second_div  =
    fan_divisor({s_r.diode.aux2_div_hi, s_r.diode.aux2_div_lo});
  assign cfg = '{diode: s_r.diode, batt: s_r.batt,
                 crit: s_r.crit, fan: s_r.fan};

  // checks
  logic rd_take;
  assign rd_take = take && !hwrite;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_maker_hi;
    rd_take && a_idx == MAKER_ID_IDX && s_n.bank.hbs
      |=> hrdata == {24'h0, MAKER_ID[15:8]};
  endproperty
  a_maker_hi: assert property (p_maker_hi) else $error("maker high byte");

  property p_maker_lo;
    rd_take && a_idx == MAKER_ID_IDX && !s_n.bank.hbs
      |=> hrdata == {24'h0, MAKER_ID[7:0]};
  endproperty
  a_maker_lo: assert property (p_maker_lo) else $error("maker low byte");

  property p_part_id;
    rd_take && a_idx == PART_ID_IDX && s_n.bank.bank == BANK_ZERO
      |=> hrdata == {24'h0, PART_ID};
  endproperty
  a_part_id: assert property (p_part_id) else $error("part id");

  property p_bank_other;
    rd_take && a_idx == BEEP_ONE_IDX && s_n.bank.bank != BANK_ZERO
      |=> hrdata == 32'h0;
  endproperty
  a_bank_other: assert property (p_bank_other) else $error("bank gate");

  property p_gate_off;
    !s_r.beep_two.gate |=> !beep;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("beep not gated");

  property p_beep_on;
    s_r.beep_two.gate && |(s_r.al1_s & s_r.beep_one) |=> beep;
  endproperty
  a_beep_on: assert property (p_beep_on) else $error("beep missing");

  property p_full_duty;
    !s_r.fan.dc_mode && s_r.out_value == DUTY_FULL |=> cpu_fan_drive_second_pwm;
  endproperty
  a_full_duty: assert property (p_full_duty) else $error("full duty");

  property p_zero_duty;
    s_r.out_value == 8'h00 |=> !cpu_fan_drive_second_pwm;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("zero duty");

  property p_dc_level;
    s_r.fan.dc_mode |=> cpu_fan_drive_second_dc == $past(s_r.out_value[7:2])
                        && !cpu_fan_drive_second_pwm;
  endproperty
  a_dc_level: assert property (p_dc_level) else $error("dc level");

  property p_prescale;
    s_r.freq.prescale != 7'h00 |-> s_r.pre_cnt <= s_r.freq.prescale;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescale range");

  property p_batt_sample;
    battery_sample |-> $past(s_r.mon_cnt) == MON_LAST && s_r.batt_en_d;
  endproperty
  a_batt_sample: assert property (p_batt_sample) else $error("batt sample");

  property p_batt_read;
    battery_sample |-> s_r.batt_read == $past(s_r.adc_s);
  endproperty
  a_batt_read: assert property (p_batt_read) else $error("batt reading");

  property p_wr_banked;
    s_r.wr_pend && s_r.wr_idx == BEEP_TWO_IDX && s_r.bank.bank != BANK_ZERO |=> $stable(s_r.beep_two);
  endproperty
  a_wr_banked: assert property (p_wr_banked) else $error("banked write");

  property p_strap;
    s_r.strap_wait == STRAP_WAIT_LAST && !s_r.strap_done
      |=> s_r.strap_done && s_r.out_value == ($past(s_r.strap_s) ? STRAP_HI_VALUE : STRAP_LO_VALUE);
  endproperty
  a_strap: assert property (p_strap) else $error("strap load");

  property p_beep_two;
    s_r.beep_two.gate && |(7'(s_r.al2_s) & 7'(s_r.beep_two)) |=> beep;
  endproperty
  a_beep_two: assert property (p_beep_two) else $error("beep two missing");

  property p_dc_zero;
    !s_r.fan.dc_mode |=> cpu_fan_drive_second_dc == 6'h00;
  endproperty
  a_dc_zero: assert property (p_dc_zero) else $error("dc in pwm mode");

  property p_rd_high_zero;
    rd_take |=> hrdata[31:8] == 24'h0;
  endproperty
  a_rd_high_zero: assert property (p_rd_high_zero) else $error("read upper bits");

  property p_pwm_step;
    src_tick && s_r.pre_cnt >= pre_last |=> s_r.pwm_cnt == 8'($past(s_r.pwm_cnt) + 8'h01);
  endproperty
  a_pwm_step: assert property (p_pwm_step) else $error("pwm step");

  c_beep: cover property (beep);
  c_pwm_wrap: cover property (s_r.pwm_cnt == 8'hFF ##1 s_r.pwm_cnt == 8'h00);
  c_batt: cover property (battery_sample);
  c_dc: cover property (s_r.fan.dc_mode ##1 !s_r.fan.dc_mode);
endmodule // hwmon_regs
`default_nettype wire

// >>> testbench/hwmon_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module hwmon_far_side #(
  parameter logic [7:0] ADC_VALUE   = 8'h96
) (
  // clock
  input  wire logic                 clock,
  // strap level asked for by the bench
  input  wire logic                 strap_level,
  // alarm conditions asked for by the bench
  input  wire hwmon_pkg::beep_one_t cmd_one,
  input  wire hwmon_pkg::beep_two_t cmd_two,
  // sensor side lines
  output hwmon_pkg::beep_one_t      alarm_one,
  output hwmon_pkg::beep_two_t      alarm_two,
  output logic [7:0]                battery_adc,
  output logic                      fan_default_strap
);
  import hwmon_pkg::*;

  // comparators update once per host clock
  always @(posedge clock)
  begin
    alarm_one <= cmd_one;
    alarm_two <= {1'h0, cmd_two[6:0]};
  end

  // battery converter holds steady; strap pin follows the level asked for by the bench
  assign battery_adc       = ADC_VALUE;
  assign fan_default_strap = strap_level;
endmodule // hwmon_far_side
`default_nettype wire

// >>> testbench/hwmon_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module hwmon_regs_tb_top;
  import hwmon_pkg::*;
  localparam int          MON   = 20;
  localparam logic [15:0] MAKER = 16'h1A2B; // arbitrary value
  localparam logic [7:0]  PART  = 8'h3D;    // arbitrary value
  localparam logic [7:0]  ADC   = 8'h96;
  logic        clock    = 1'h0;
  logic        rst      = 1'h1;
  logic        hsel     = 1'h0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'h0;
  logic [2:0]  hsize    = HSIZE_WORD;
  logic [31:0] hwdata   = 32'h0;
  beep_one_t   cmd_one  = 8'h00;
  beep_two_t   cmd_two  = 8'h00;
  logic        strap_cmd = 1'h1;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  beep_one_t   alarm_one;
  beep_two_t   alarm_two;
  logic [7:0]  battery_adc;
  logic        strap;
  logic        beep;
  logic        battery_sample;
  logic        pwm;
  logic [5:0]  dc;
  logic [7:0]  div;
  cfg_t        cfg;
  logic [31:0] rd;
  int          n_errors = 0;
  int          compares = 0;

  always #4 clock = ~clock;

  hwmon_regs #(.MAKER_ID(MAKER), .PART_ID(PART), .MON_CYCLE_CYCLES(MON)) dut_u (
    .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .alarm_one(alarm_one), .alarm_two(alarm_two), .battery_adc(battery_adc),
    .fan_default_strap(strap), .beep(beep), .battery_sample(battery_sample),
    .cpu_fan_drive_second_pwm(pwm), .cpu_fan_drive_second_dc(dc),
    .aux_fan_tach_second_div(div), .cfg(cfg));

  hwmon_far_side #(.ADC_VALUE(ADC)) far_u (
    .clock(clock), .strap_level(strap_cmd), .cmd_one(cmd_one), .cmd_two(cmd_two), .alarm_one(alarm_one),
    .alarm_two(alarm_two), .battery_adc(battery_adc), .fan_default_strap(strap));

  task automatic test_done;
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one single transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    hsel   <= 1'h1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge clock);
    while (hready !== 1'h1) @(posedge clock);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge clock);
    while (hready !== 1'h1) @(posedge clock);
    rd = hrdata;
  endtask

  task automatic rchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    bus(1'h0, idx, 8'h00);
    chk(name, {24'h0, exp}, rd);
  endtask

  task automatic t_reset;
    logic [7:0] idx [9];
    logic [7:0] val [9];
    idx = '{BANK_CTL_IDX, BEEP_ONE_IDX, BEEP_TWO_IDX, PART_ID_IDX, DIODE_IDX, BATT_CTL_IDX,
            CRIT_IDX, PWM_FREQ_IDX, FAN_CFG_IDX};
    val = '{8'h80, 8'h00, 8'h80, PART, 8'h70, 8'h04, 8'h04, 8'h04, 8'h40};
    for (int i = 0; i < 9; i++) rchk("reset value", idx[i], val[i]);
    rchk("strap value", OUT_VALUE_IDX, STRAP_HI_VALUE);
    chk("dc level", {26'h0, STRAP_HI_VALUE[7:2]}, {26'h0, dc});
    chk("pwm in dc mode", 32'h0, {31'h0, pwm});
    chk("cfg reset", 32'h70040440, cfg);
  endtask

  task automatic t_rw;
    logic [7:0] idx [7];
    logic [7:0] msk [7];
    logic [7:0] pat;
    idx = '{BEEP_ONE_IDX, BEEP_TWO_IDX, DIODE_IDX, BATT_CTL_IDX, CRIT_IDX, OUT_VALUE_IDX, FAN_CFG_IDX};
    msk = '{8'hFF, 8'hFF, 8'hFF, 8'hEF, 8'hFE, 8'hFF, 8'h7F};
    for (int p = 0; p < 2; p++)
    begin
      pat = (p == 0) ? 8'hFF : 8'h00;
      for (int i = 0; i < 7; i++) bus(1'h1, idx[i], pat);
      for (int i = 0; i < 7; i++) rchk("readback", idx[i], pat & msk[i]);
      chk("cfg", {pat, pat & 8'hEF, pat & 8'hFE, pat & 8'h7F}, cfg);
    end
    for (int c = 0; c < 8; c++)
    begin
      bus(1'h1, DIODE_IDX, {c[2], 3'h7, c[1:0], 2'h0});
      rchk("diode", DIODE_IDX, {c[2], 3'h7, c[1:0], 2'h0});
      chk("divisor", 32'h1 << c, {24'h0, div});
    end
    for (int m = 0; m < 4; m++)
    begin
      bus(1'h1, FAN_CFG_IDX, {2'h0, m[1:0], 4'hA});
      rchk("fan cfg", FAN_CFG_IDX, {2'h0, m[1:0], 4'hA});
      chk("mode", {30'h0, m[1:0]}, {30'h0, cfg.fan.mode});
    end
  endtask

  task automatic t_bank;
    bus(1'h1, BEEP_TWO_IDX, 8'h80);
    bus(1'h1, BANK_CTL_IDX, 8'h01);
    rchk("banked away", BEEP_TWO_IDX, 8'h00);
    bus(1'h1, BEEP_TWO_IDX, 8'h00);
    rchk("maker low", MAKER_ID_IDX, MAKER[7:0]);
    bus(1'h1, BANK_CTL_IDX, 8'h80);
    rchk("maker high", MAKER_ID_IDX, MAKER[15:8]);
    rchk("bank zero", BEEP_TWO_IDX, 8'h80);
    bus(1'h1, PART_ID_IDX, 8'h00);
    rchk("part id", PART_ID_IDX, PART);
  endtask

  task automatic beep_is(input logic exp);
    repeat (8) @(posedge clock);
    chk("beep", {31'h0, exp}, {31'h0, beep});
  endtask

  task automatic t_beep;
    bus(1'h1, BEEP_ONE_IDX, 8'h80);
    cmd_two <= 8'h40;
    beep_is(1'h0);
    cmd_one <= 8'h80;
    beep_is(1'h1);
    bus(1'h1, BEEP_TWO_IDX, 8'h00);
    beep_is(1'h0);
    cmd_one <= 8'h00;
    cmd_two <= 8'h10;
    bus(1'h1, BEEP_TWO_IDX, 8'h90);
    beep_is(1'h1);
    cmd_two <= 8'h00;
    beep_is(1'h0);
  endtask

  task automatic t_batt;
    int n;
    bus(1'h1, BATT_CTL_IDX, 8'h01);
    for (n = 0; n < MON + 10 && battery_sample !== 1'h1; n++) @(negedge clock);
    chk("monitor cycle", 32'h1, {31'h0, n >= MON && n <= MON + 2});
    @(posedge clock);
    rchk("battery reading", BATT_READ_IDX, ADC);
  endtask

  task automatic pwm_level(input logic [7:0] value, input logic exp);
    int bad;
    bus(1'h1, OUT_VALUE_IDX, value);
    repeat (4) @(posedge clock);
    bad = 0;
    repeat (1400)
    begin
      @(posedge clock);
      bad += (pwm !== exp);
    end
    chk("steady pwm", 32'h0, bad);
  endtask

  task automatic t_period(input logic [6:0] pre);
    int n;
    int a;
    int b;
    int exp;
    exp = 256 * pre * SYS_CLK_KHZ / PWM_FAST_KHZ;
    bus(1'h1, PWM_FREQ_IDX, {1'h0, pre});
    for (n = 0; n < 3000 && pwm !== 1'h0; n++) @(posedge clock);
    for (n = 0; n < 6000 && pwm !== 1'h1; n++) @(posedge clock);
    for (a = 0; a < 6000 && pwm !== 1'h0; a++) @(posedge clock);
    for (b = 0; b < 6000 && pwm !== 1'h1; b++) @(posedge clock);
    chk("pwm period", 32'h1, {31'h0, a + b >= exp - 3 && a + b <= exp + 3});
    chk("pwm duty", 32'h1, {31'h0, a >= exp / 2 - 4 && a <= exp / 2 + 4});
  endtask

  task automatic t_pwm;
    bus(1'h1, FAN_CFG_IDX, 8'h00);
    bus(1'h1, PWM_FREQ_IDX, 8'h01);
    pwm_level(8'hFF, 1'h1);
    pwm_level(8'h00, 1'h0);
    bus(1'h1, OUT_VALUE_IDX, 8'h80);
    t_period(7'h01);
    t_period(7'h02);
    bus(1'h1, FAN_CFG_IDX, 8'h40);
    bus(1'h1, OUT_VALUE_IDX, 8'hB7);
    repeat (4) @(posedge clock);
    chk("dc level", 32'h2D, {26'h0, dc});
    chk("pwm in dc mode", 32'h0, {31'h0, pwm});
  endtask

  // second reset with the strap low, then the slow pwm source
  task automatic t_strap;
    int n;
    strap_cmd <= 1'h0;
    rst       <= 1'h1;
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    repeat (5) @(posedge clock);
    rchk("strap low", OUT_VALUE_IDX, STRAP_LO_VALUE);
    rchk("reset value", BEEP_TWO_IDX, 8'h80);
    chk("dc level", {26'h0, STRAP_LO_VALUE[7:2]}, {26'h0, dc});
    bus(1'h1, FAN_CFG_IDX, 8'h00);
    bus(1'h1, PWM_FREQ_IDX, 8'h81);
    bus(1'h1, OUT_VALUE_IDX, 8'h01);
    for (n = 0; n < 2000 && pwm !== 1'h0; n++) @(negedge clock);
    chk("slow source", 32'h1, {31'h0, n >= SYS_CLK_KHZ / PWM_SLOW_KHZ - 40
                                   && n <= SYS_CLK_KHZ / PWM_SLOW_KHZ});
  endtask

  initial
  begin
    repeat (5) @(posedge clock);
    rst <= 1'h0;
    repeat (5) @(posedge clock);
    t_reset;
    t_rw;
    t_bank;
    t_beep;
    t_batt;
    t_pwm;
    t_strap;
    test_done;
  end

  initial
  begin
    repeat (40000) @(posedge clock);
    n_errors++;
    test_done;
  end
endmodule // hwmon_regs_tb_top
`default_nettype wire
